// file: hw/cst_pkg.sv
// constants, types and helpers shared by the subtract/transfer/test slice
package cst_pkg;

	// opcode bytes
	localparam logic [7:0] OP_PREFIX_Y = 8'h18;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_A_IMM = 8'h80;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_A_DIR = 8'h90;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_A_EXT = 8'hb0;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_A_IDX = 8'ha0;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_B_IMM = 8'hc0;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_B_DIR = 8'hd0;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_B_EXT = 8'hf0;
	localparam logic [7:0] OP_SUB_MEM_FROM_ACC_B_IDX = 8'he0;
	localparam logic [7:0] OP_SUB_WORD_FROM_ACC_D_IMM = 8'h83;
	localparam logic [7:0] OP_SUB_WORD_FROM_ACC_D_DIR = 8'h93;
	localparam logic [7:0] OP_SUB_WORD_FROM_ACC_D_EXT = 8'hb3;
	localparam logic [7:0] OP_SUB_WORD_FROM_ACC_D_IDX = 8'ha3;
	localparam logic [7:0] OP_FLAGS_FROM_A = 8'h06;
	localparam logic [7:0] OP_FLAGS_TO_A = 8'h07;
	localparam logic [7:0] OP_TST_EXT = 8'h7d;
	localparam logic [7:0] OP_TST_IDX = 8'h6d;
	localparam logic [7:0] OP_TST_A = 8'h4d;
	localparam logic [7:0] OP_TST_B = 8'h5d;
	localparam logic [7:0] OP_SP_TO_IDX = 8'h30;
	localparam logic [7:0] OP_IDX_TO_SP = 8'h35;
	localparam logic [7:0] OP_WAIT_IRQ = 8'h3e;
	localparam logic [7:0] OP_SWAP_D = 8'h8f;
	localparam logic [7:0] OP_TEST = 8'h00;

	// flag register bit positions and reset value
	localparam int CC_S = 7;
	localparam int CC_X = 6;
	localparam int CC_H = 5;
	localparam int CC_I = 4;
	localparam int CC_N = 3;
	localparam int CC_Z = 2;
	localparam int CC_V = 1;
	localparam int CC_C = 0;
	localparam logic [7:0] FLAGS_RESET = 8'hd0;

	// E-cycle counts without the Y prefix
	localparam logic [3:0] CYC_INH = 4'h2;
	localparam logic [3:0] CYC_XFER = 4'h3;
	localparam logic [3:0] CYC_B_DIR = 4'h3;
	localparam logic [3:0] CYC_B_EXT = 4'h4;
	localparam logic [3:0] CYC_W_IMM = 4'h4;
	localparam logic [3:0] CYC_W_DIR = 4'h5;
	localparam logic [3:0] CYC_W_EXT = 4'h6;
	localparam logic [3:0] CYC_TST_MEM = 4'h6;
	localparam logic [3:0] CYC_WAI_STACK = 4'hc;
	localparam logic [3:0] WAI_WR_FIRST = 4'h2;
	localparam logic [3:0] WAI_WR_LAST = 4'ha;
	localparam logic [3:0] CYC_VECTOR = 4'h2;

	typedef enum logic [3:0] {
		K_NOP = 4'h0, K_SUB_MEM_FROM_ACC_A = 4'h1, K_SUB_MEM_FROM_ACC_B = 4'h2, K_SUB_WORD_FROM_ACC_D = 4'h3,
		K_TAP = 4'h4, K_TPA = 4'h5, K_TST = 4'h6, K_TEST_ACC_A_SIGN_ZERO = 4'h7,
		K_TEST_ACC_B_SIGN_ZERO = 4'h8, K_TSX = 4'h9, K_TXS = 4'ha, K_XGD = 4'hb,
		K_WAI = 4'hc, K_TEST = 4'hd
	} cst_kind_t;

	typedef enum logic [2:0] {
		AM_INH = 3'h0, AM_IMM = 3'h1, AM_DIR = 3'h2, AM_EXT = 3'h3, AM_IDX = 3'h4
	} cst_amode_t;

	typedef struct packed {
		cst_kind_t kind;
		cst_amode_t amode;
		logic wide;
		logic [1:0] nopnd;
		logic [3:0] cycles;
	} cst_dec_t;

	function automatic cst_dec_t cst_decode(input logic [7:0] op);
		cst_dec_t d;
		d = '{K_NOP, AM_INH, 1'b0, 2'h0, CYC_INH};
		case (op)
			OP_SUB_MEM_FROM_ACC_A_IMM: d = '{K_SUB_MEM_FROM_ACC_A, AM_IMM, 1'b0, 2'h1, CYC_INH};
			OP_SUB_MEM_FROM_ACC_A_DIR: d = '{K_SUB_MEM_FROM_ACC_A, AM_DIR, 1'b0, 2'h1, CYC_B_DIR};
			OP_SUB_MEM_FROM_ACC_A_EXT: d = '{K_SUB_MEM_FROM_ACC_A, AM_EXT, 1'b0, 2'h2, CYC_B_EXT};
			OP_SUB_MEM_FROM_ACC_A_IDX: d = '{K_SUB_MEM_FROM_ACC_A, AM_IDX, 1'b0, 2'h1, CYC_B_EXT};
			OP_SUB_MEM_FROM_ACC_B_IMM: d = '{K_SUB_MEM_FROM_ACC_B, AM_IMM, 1'b0, 2'h1, CYC_INH};
			OP_SUB_MEM_FROM_ACC_B_DIR: d = '{K_SUB_MEM_FROM_ACC_B, AM_DIR, 1'b0, 2'h1, CYC_B_DIR};
			OP_SUB_MEM_FROM_ACC_B_EXT: d = '{K_SUB_MEM_FROM_ACC_B, AM_EXT, 1'b0, 2'h2, CYC_B_EXT};
			OP_SUB_MEM_FROM_ACC_B_IDX: d = '{K_SUB_MEM_FROM_ACC_B, AM_IDX, 1'b0, 2'h1, CYC_B_EXT};
			OP_SUB_WORD_FROM_ACC_D_IMM: d = '{K_SUB_WORD_FROM_ACC_D, AM_IMM, 1'b1, 2'h2, CYC_W_IMM};
			OP_SUB_WORD_FROM_ACC_D_DIR: d = '{K_SUB_WORD_FROM_ACC_D, AM_DIR, 1'b1, 2'h1, CYC_W_DIR};
			OP_SUB_WORD_FROM_ACC_D_EXT: d = '{K_SUB_WORD_FROM_ACC_D, AM_EXT, 1'b1, 2'h2, CYC_W_EXT};
			OP_SUB_WORD_FROM_ACC_D_IDX: d = '{K_SUB_WORD_FROM_ACC_D, AM_IDX, 1'b1, 2'h1, CYC_W_EXT};
			OP_FLAGS_FROM_A: d = '{K_TAP, AM_INH, 1'b0, 2'h0, CYC_INH};
			OP_FLAGS_TO_A: d = '{K_TPA, AM_INH, 1'b0, 2'h0, CYC_INH};
			OP_TST_EXT: d = '{K_TST, AM_EXT, 1'b0, 2'h2, CYC_TST_MEM};
			OP_TST_IDX: d = '{K_TST, AM_IDX, 1'b0, 2'h1, CYC_TST_MEM};
			OP_TST_A: d = '{K_TEST_ACC_A_SIGN_ZERO, AM_INH, 1'b0, 2'h0, CYC_INH};
			OP_TST_B: d = '{K_TEST_ACC_B_SIGN_ZERO, AM_INH, 1'b0, 2'h0, CYC_INH};
			OP_SP_TO_IDX: d = '{K_TSX, AM_INH, 1'b0, 2'h0, CYC_XFER};
			OP_IDX_TO_SP: d = '{K_TXS, AM_INH, 1'b0, 2'h0, CYC_XFER};
			OP_SWAP_D: d = '{K_XGD, AM_INH, 1'b0, 2'h0, CYC_XFER};
			OP_WAIT_IRQ: d = '{K_WAI, AM_INH, 1'b0, 2'h0, CYC_WAI_STACK};
			OP_TEST: d = '{K_TEST, AM_INH, 1'b0, 2'h0, CYC_INH};
			default: d = '{K_NOP, AM_INH, 1'b0, 2'h0, CYC_INH};
		endcase
		return d;
	endfunction : cst_decode

	function automatic logic [15:0] cst_eff_addr(input cst_amode_t am, input logic [7:0] b1,
			input logic [7:0] b2, input logic [15:0] idx);
		case (am)
			AM_DIR: return {8'h00, b1};
			AM_IDX: return idx + {8'h00, b1};
			default: return {b1, b2};
		endcase
	endfunction : cst_eff_addr

	function automatic logic [15:0] cst_rel_target(input logic [15:0] next_pc,
			input logic [7:0] off);
		return next_pc + {{8{off[7]}}, off};
	endfunction : cst_rel_target

endpackage : cst_pkg

// file: hw/cst_alu.sv
// result and flag computation for the subtract, test and flag-load operations
`timescale 1ns/100ps
module cst_alu
	import cst_pkg::*;
(
	input wire cst_kind_t kind_in,
	input wire logic [7:0] acc_a_in,
	input wire logic [7:0] acc_b_in,
	input wire logic [7:0] flags_in,
	input wire logic [7:0] byte_in,
	input wire logic [15:0] word_in,
	output logic [7:0] res8_out,
	output logic [15:0] res16_out,
	output logic [7:0] flags_out
);

	logic [8:0] diff8;
	logic [16:0] diff16;
	logic [7:0] minuend8;
	logic [7:0] tested;

	always_comb begin
		minuend8 = (kind_in == K_SUB_MEM_FROM_ACC_B) ? acc_b_in : acc_a_in;
		diff8 = {1'b0, minuend8} - {1'b0, byte_in};
		diff16 = {1'b0, acc_a_in, acc_b_in} - {1'b0, word_in};
		res8_out = diff8[7:0];
		res16_out = diff16[15:0];
		tested = (kind_in == K_TEST_ACC_A_SIGN_ZERO) ? acc_a_in : ((kind_in == K_TEST_ACC_B_SIGN_ZERO) ? acc_b_in : byte_in);
		flags_out = flags_in;
		case (kind_in)
			K_SUB_MEM_FROM_ACC_A, K_SUB_MEM_FROM_ACC_B: begin
				flags_out[CC_N] = diff8[7];
				flags_out[CC_Z] = (diff8[7:0] == 8'h00);
				flags_out[CC_V] = (minuend8[7] ^ byte_in[7]) & (minuend8[7] ^ diff8[7]);
				flags_out[CC_C] = diff8[8];
			end
			K_SUB_WORD_FROM_ACC_D: begin
				flags_out[CC_N] = diff16[15];
				flags_out[CC_Z] = (diff16[15:0] == 16'h0000);
				flags_out[CC_V] = (acc_a_in[7] ^ word_in[15]) & (acc_a_in[7] ^ diff16[15]);
				flags_out[CC_C] = diff16[16];
			end
			K_TST, K_TEST_ACC_A_SIGN_ZERO, K_TEST_ACC_B_SIGN_ZERO: begin
				flags_out[CC_N] = tested[7];
				flags_out[CC_Z] = (tested == 8'h00);
				flags_out[CC_V] = 1'b0;
				flags_out[CC_C] = 1'b0;
			end
			K_TAP: begin
				flags_out = acc_a_in;
				flags_out[CC_X] = flags_in[CC_X] & acc_a_in[CC_X];
			end
			default: flags_out = flags_in;
		endcase
	end

endmodule : cst_alu

// file: hw/cst_core.sv
// sequencer, addressing, registers and bus for the subtract/transfer/test slice
`timescale 1ns/100ps

// Function
// - subtract memory byte from A
// - subtract memory byte from B
// - subtract memory word from D
// - copy A into flag register
// - copy flag register into A
// - test memory byte, clear V and C
// - test A or B against zero
// - X gets stack pointer plus one
// - Y gets stack pointer plus one
// - stack pointer gets index minus one
// - opcode 00 runs address bus forever
// - wait: stack, idle, fetch vector
// - direct address has zero high byte
// - indexed adds unsigned byte to index
// - relative offset signed from next byte
// - flag loads never set X mask
module cst_core
	import cst_pkg::*;
#(
	parameter int E_DIV = 4,
	parameter logic [15:0] RESET_PC = 16'h0000,
	parameter logic [15:0] SP_RESET = 16'h00ff,
	parameter logic [15:0] IRQ_VECTOR = 16'hfff2
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic test_mode_in,
	input wire logic irq_n_in,
	input wire logic [7:0] data_in,
	output logic [15:0] addr_out,
	output logic rw_out,
	output logic [7:0] data_out,
	output logic e_tick_out,
	output logic inst_done_out,
	output logic waiting_out,
	output logic [15:0] branch_target_out,
	output logic [7:0] acc_a_out,
	output logic [7:0] acc_b_out,
	output logic [7:0] flags_out,
	output logic [15:0] index_x_out,
	output logic [15:0] index_y_out,
	output logic [15:0] stackptr_out,
	output logic [15:0] pc_out
);

	// refuse divider settings the 12-bit counter cannot serve
	if (E_DIV < 1 || E_DIV > 4096) begin : g_bad_div
		$error("cst_core: E_DIV out of range");
	end

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00, ST_WAIT = 2'b01, ST_VEC = 2'b10, ST_TEST = 2'b11
	} cst_state_t;

	cst_state_t state_reg;
	cst_dec_t dec_reg;
	logic [11:0] div_reg;
	logic e_tick;
	logic [1:0] test_sync_reg, irq_sync_reg;
	logic [3:0] cyc_reg;
	logic pre_reg;
	logic [7:0] b1_reg, b2_reg, mhi_reg;
	logic [15:0] pc_reg, sp_reg, ix_reg, iy_reg, test_addr_reg, branch_target_reg;
	logic [7:0] acc_a_reg, acc_b_reg, flags_reg;
	logic done_reg;
	logic [3:0] last_cyc;
	logic in_body, opc_cyc, opnd_cyc, mem_cyc, wai_wr, finish, irq_seen;
	cst_dec_t dec_now;
	logic [15:0] idx_sel, ea;
	logic [7:0] alu_res8, alu_flags;
	logic [15:0] alu_res16, opnd_word;

	// E clock as a one-cycle enable; every bus cycle lasts one E period
	always_ff @(posedge clk_in) begin
		if (srst_in || div_reg == 12'(E_DIV - 1)) div_reg <= 12'h000;
		else div_reg <= div_reg + 12'h001;
	end
	assign e_tick = !srst_in && (div_reg == 12'(E_DIV - 1));

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			test_sync_reg <= 2'b00;
			irq_sync_reg <= 2'b11;
		end else begin
			test_sync_reg <= {test_sync_reg[0], test_mode_in};
			irq_sync_reg <= {irq_sync_reg[0], irq_n_in};
		end
	end

	assign irq_seen = !irq_sync_reg[1] && !flags_reg[CC_I];

	always_comb begin
		dec_now = cst_decode(data_in);
		if (dec_now.kind == K_TEST && !test_sync_reg[1]) dec_now.kind = K_NOP;
	end

	// prefix adds one cycle to every Y form
	assign last_cyc = dec_reg.cycles + {3'h0, pre_reg} - 4'h1;
	assign in_body = state_reg == ST_EXEC && cyc_reg > {3'h0, pre_reg};
	assign opc_cyc = state_reg == ST_EXEC && cyc_reg == {3'h0, pre_reg};
	assign opnd_cyc = in_body && cyc_reg <= {3'h0, pre_reg} + {2'h0, dec_reg.nopnd};
	assign mem_cyc = in_body && !opnd_cyc && dec_reg.amode != AM_INH && dec_reg.amode != AM_IMM
		&& (cyc_reg == last_cyc || (dec_reg.wide && cyc_reg == last_cyc - 4'h1));
	assign wai_wr = in_body && dec_reg.kind == K_WAI && cyc_reg >= WAI_WR_FIRST
		&& cyc_reg <= WAI_WR_LAST;
	assign finish = e_tick && in_body && cyc_reg == last_cyc;

	assign idx_sel = pre_reg ? iy_reg : ix_reg;
	assign ea = cst_eff_addr(dec_reg.amode, b1_reg, b2_reg, idx_sel);

	always_comb begin
		addr_out = pc_reg;
		rw_out = 1'b1;
		data_out = 8'h00;
		unique case (state_reg)
			ST_TEST: addr_out = test_addr_reg;
			ST_VEC: addr_out = IRQ_VECTOR + {15'h0000, cyc_reg[0]};
			ST_WAIT: addr_out = pc_reg;
			ST_EXEC: begin
				if (wai_wr) begin
					addr_out = sp_reg;
					rw_out = 1'b0;
					unique case (cyc_reg)
						4'h2: data_out = pc_reg[7:0];
						4'h3: data_out = pc_reg[15:8];
						4'h4: data_out = iy_reg[7:0];
						4'h5: data_out = iy_reg[15:8];
						4'h6: data_out = ix_reg[7:0];
						4'h7: data_out = ix_reg[15:8];
						4'h8: data_out = acc_a_reg;
						4'h9: data_out = acc_b_reg;
						default: data_out = flags_reg;
					endcase
				end else if (mem_cyc) begin
					addr_out = (dec_reg.wide && cyc_reg == last_cyc) ? ea + 16'h0001 : ea;
				end
			end
		endcase
	end

	// sequencing of cycles within an instruction and between states
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= ST_EXEC;
			cyc_reg <= 4'h0;
			pre_reg <= 1'b0;
			dec_reg <= '{K_NOP, AM_INH, 1'b0, 2'h0, CYC_INH};
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
			mhi_reg <= 8'h00;
			test_addr_reg <= 16'h0000;
			branch_target_reg <= 16'h0000;
		end else if (e_tick) begin
			unique case (state_reg)
				ST_EXEC: begin
					if (cyc_reg == 4'h0 && !pre_reg && data_in == OP_PREFIX_Y) begin
						pre_reg <= 1'b1;
						cyc_reg <= 4'h1;
					end else if (opc_cyc) begin
						dec_reg <= dec_now;
						cyc_reg <= cyc_reg + 4'h1;
						if (dec_now.kind == K_TEST) begin
							state_reg <= ST_TEST;
							test_addr_reg <= pc_reg + 16'h0001;
						end
					end else if (cyc_reg == last_cyc) begin
						cyc_reg <= 4'h0;
						pre_reg <= 1'b0;
						if (dec_reg.kind == K_WAI) state_reg <= ST_WAIT;
					end else begin
						cyc_reg <= cyc_reg + 4'h1;
					end
					if (opnd_cyc) begin
						if (cyc_reg == {3'h0, pre_reg} + 4'h1) b1_reg <= data_in;
						else b2_reg <= data_in;
						branch_target_reg <= cst_rel_target(pc_reg + 16'h0001, data_in);
					end
					if (mem_cyc && cyc_reg != last_cyc) mhi_reg <= data_in;
				end
				ST_WAIT: begin
					if (irq_seen) state_reg <= ST_VEC;
				end
				ST_VEC: begin
					if (cyc_reg == CYC_VECTOR - 4'h1) begin
						cyc_reg <= 4'h0;
						state_reg <= ST_EXEC;
					end else begin
						cyc_reg <= cyc_reg + 4'h1;
						b1_reg <= data_in;
					end
				end
				ST_TEST: begin
					test_addr_reg <= test_addr_reg + 16'h0001;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) pc_reg <= RESET_PC;
		else if (e_tick && state_reg == ST_EXEC && (cyc_reg <= {3'h0, pre_reg} || opnd_cyc))
			pc_reg <= pc_reg + 16'h0001;
		else if (e_tick && state_reg == ST_VEC && cyc_reg == CYC_VECTOR - 4'h1)
			pc_reg <= {b1_reg, data_in};
	end

	assign opnd_word = (dec_reg.amode == AM_IMM) ? {b1_reg, b2_reg} : {mhi_reg, data_in};

	cst_alu u_alu (
		.kind_in(dec_reg.kind),
		.acc_a_in(acc_a_reg),
		.acc_b_in(acc_b_reg),
		.flags_in(flags_reg),
		.byte_in(data_in),
		.word_in(opnd_word),
		.res8_out(alu_res8),
		.res16_out(alu_res16),
		.flags_out(alu_flags)
	);

	// programmer-visible registers, written on the last cycle of each instruction; sp_reg also on each wait stacking write, I on the first vector fetch
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			acc_a_reg <= 8'h00;
			acc_b_reg <= 8'h00;
			flags_reg <= FLAGS_RESET;
			ix_reg <= 16'h0000;
			iy_reg <= 16'h0000;
			sp_reg <= SP_RESET;
		end else if (e_tick && wai_wr) begin
			sp_reg <= sp_reg - 16'h0001;
		end else if (e_tick && state_reg == ST_VEC && cyc_reg == 4'h0) begin
			flags_reg[CC_I] <= 1'b1;
		end else if (finish) begin
			case (dec_reg.kind)
				K_SUB_MEM_FROM_ACC_A: begin
					acc_a_reg <= alu_res8;
					flags_reg <= alu_flags;
				end
				K_SUB_MEM_FROM_ACC_B: begin
					acc_b_reg <= alu_res8;
					flags_reg <= alu_flags;
				end
				K_SUB_WORD_FROM_ACC_D: begin
					{acc_a_reg, acc_b_reg} <= alu_res16;
					flags_reg <= alu_flags;
				end
				K_TPA: acc_a_reg <= flags_reg;
				K_TAP, K_TST, K_TEST_ACC_A_SIGN_ZERO, K_TEST_ACC_B_SIGN_ZERO: flags_reg <= alu_flags;
				K_TSX: begin
					if (pre_reg) iy_reg <= sp_reg + 16'h0001;
					else ix_reg <= sp_reg + 16'h0001;
				end
				K_TXS: sp_reg <= idx_sel - 16'h0001;
				K_XGD: begin
					{acc_a_reg, acc_b_reg} <= idx_sel;
					if (pre_reg) iy_reg <= {acc_a_reg, acc_b_reg};
					else ix_reg <= {acc_a_reg, acc_b_reg};
				end
				default: acc_a_reg <= acc_a_reg;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) done_reg <= 1'b0;
		else done_reg <= finish && dec_reg.kind != K_WAI;
	end

	assign e_tick_out = e_tick;
	assign inst_done_out = done_reg;
	assign waiting_out = state_reg == ST_WAIT;
	assign branch_target_out = branch_target_reg;
	assign acc_a_out = acc_a_reg;
	assign acc_b_out = acc_b_reg;
	assign flags_out = flags_reg;
	assign index_x_out = ix_reg;
	assign index_y_out = iy_reg;
	assign stackptr_out = sp_reg;
	assign pc_out = pc_reg;

	// helper: E cycles since the instruction's first fetch
	logic [4:0] len_reg;
	always_ff @(posedge clk_in) begin
		if (srst_in || finish) len_reg <= 5'h00;
		else if (e_tick && state_reg == ST_EXEC) len_reg <= len_reg + 5'h01;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_sub_mem_from_acc_a_imm_len: assert property (finish && dec_reg.kind == K_SUB_MEM_FROM_ACC_A
		&& dec_reg.amode == AM_IMM |-> len_reg == 5'h01) else $error("immediate sub not 2 cycles");
	a_sub_mem_from_acc_b_idy_len: assert property (finish && dec_reg.kind == K_SUB_MEM_FROM_ACC_B && pre_reg
		&& dec_reg.amode == AM_IDX |-> len_reg == 5'h04) else $error("sub B via Y not 5 cycles");
	a_sub_word_from_acc_d_ext_len: assert property (finish && dec_reg.kind == K_SUB_WORD_FROM_ACC_D
		&& dec_reg.amode == AM_EXT |-> len_reg == 5'h05) else $error("word sub ext not 6 cycles");
	a_tap_xmask: assert property (finish && dec_reg.kind == K_TAP
		|=> !(flags_reg[CC_X] && !$past(flags_reg[CC_X]))) else $error("flag load set X mask");
	a_tap_copy: assert property (finish && dec_reg.kind == K_TAP
		|=> flags_reg[5:0] == $past(acc_a_reg[5:0])) else $error("flags not loaded from A");
	a_tpa_keep: assert property (finish && dec_reg.kind == K_TPA
		|=> acc_a_reg == $past(flags_reg) && $stable(flags_reg)) else $error("flag copy wrong");
	a_tst_clear: assert property (finish && dec_reg.kind inside {K_TST, K_TEST_ACC_A_SIGN_ZERO, K_TEST_ACC_B_SIGN_ZERO}
		|=> !flags_reg[CC_V] && !flags_reg[CC_C] && $stable(acc_a_reg) && $stable(acc_b_reg))
		else $error("test altered V, C or accumulator");
	a_tst_idy_len: assert property (finish && dec_reg.kind == K_TST && pre_reg
		|-> len_reg == 5'h06) else $error("memory test via Y not 7 cycles");
	a_tsx_value: assert property (finish && dec_reg.kind == K_TSX && !pre_reg
		|=> ix_reg == $past(sp_reg) + 16'h0001) else $error("X not stack pointer plus one");
	a_tsy_value: assert property (finish && dec_reg.kind == K_TSX && pre_reg
		|-> len_reg == 5'h03 ##1 iy_reg == $past(sp_reg) + 16'h0001) else $error("Y transfer bad");
	a_txs_value: assert property (finish && dec_reg.kind == K_TXS
		|=> sp_reg == $past(idx_sel) - 16'h0001 && $stable(flags_reg)) else $error("sp load bad");
	a_swap_pair: assert property (finish && dec_reg.kind == K_XGD && !pre_reg
		|=> {acc_a_reg, acc_b_reg} == $past(ix_reg) && ix_reg == $past({acc_a_reg, acc_b_reg}))
		else $error("D and X not exchanged");
	a_dir_high_zero: assert property (mem_cyc && dec_reg.amode == AM_DIR
		&& !(dec_reg.wide && cyc_reg == last_cyc) |-> addr_out == {8'h00, b1_reg})
		else $error("direct address high byte not zero");
	a_idx_add: assert property (mem_cyc && dec_reg.amode == AM_IDX && !dec_reg.wide
		|-> addr_out == idx_sel + {8'h00, b1_reg}) else $error("indexed address wrong");
	a_wai_stack_len: assert property (finish && dec_reg.kind == K_WAI
		|-> len_reg == 5'h0b ##1 state_reg == ST_WAIT) else $error("wait stacking not 12 cycles");
	a_test_runs: assert property (e_tick && state_reg == ST_TEST
		|=> state_reg == ST_TEST && test_addr_reg == $past(test_addr_reg) + 16'h0001)
		else $error("test opcode stopped incrementing");

	c_sub_word_from_acc_d_done: cover property (finish && dec_reg.kind == K_SUB_WORD_FROM_ACC_D);
	c_wait_wake: cover property (state_reg == ST_WAIT ##1 state_reg == ST_VEC);
	c_test_run: cover property (state_reg == ST_TEST);
	c_swap_y: cover property (finish && dec_reg.kind == K_XGD && pre_reg);

endmodule : cst_core

// file: verification/cpu_subtract_transfer_test_ops_tb.sv
// self-checking bench for the subtract, transfer and test slice
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin err_total++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, sn); end end
module cpu_subtract_transfer_test_ops_tb;
	import cst_pkg::*;
	localparam int EDIV = 2;
	typedef struct packed {
		logic [7:0] a, b, f;
		logic [15:0] x, y, sp;
		logic [3:0] cyc;
		logic bv;
		logic [15:0] bt;
	} cst_exp_t;
	logic clk_in = 1'b0, srst_in = 1'b1, test_mode_in = 1'b0, irq_n_in = 1'b1;
	logic [7:0] data_in = 8'h00;
	logic [15:0] addr_out, branch_target_out, index_x_out, index_y_out, stackptr_out, pc_out;
	logic rw_out, e_tick_out, inst_done_out, waiting_out;
	logic [7:0] data_out, acc_a_out, acc_b_out, flags_out;
	logic [7:0] mem [0:65535];
	logic [7:0] ma, mb, mf;
	logic [15:0] mx, my, msp, pc;
	cst_exp_t q[$];
	int seed, err_total, compares, clk_cnt, last_done;
	const int cyc_tab [5] = '{2, 3, 4, 4, 5};

	cst_core #(.E_DIV(EDIV), .RESET_PC(16'h8000), .SP_RESET(16'h01ff), .IRQ_VECTOR(16'hfff2)) i_dut (
		.clk_in(clk_in), .srst_in(srst_in), .test_mode_in(test_mode_in), .irq_n_in(irq_n_in),
		.data_in(data_in), .addr_out(addr_out), .rw_out(rw_out), .data_out(data_out),
		.e_tick_out(e_tick_out), .inst_done_out(inst_done_out), .waiting_out(waiting_out),
		.branch_target_out(branch_target_out), .acc_a_out(acc_a_out), .acc_b_out(acc_b_out),
		.flags_out(flags_out), .index_x_out(index_x_out), .index_y_out(index_y_out),
		.stackptr_out(stackptr_out), .pc_out(pc_out));

	initial begin
		forever #5 clk_in = ~clk_in;
	end

	// memory answers off the sampling edge; writes land at the tick closing the E cycle
	always @(negedge clk_in) data_in <= mem[addr_out];
	always @(posedge clk_in) if (e_tick_out === 1'b1 && rw_out === 1'b0) mem[addr_out] <= data_out;

	task automatic emit(input logic [7:0] v);
		mem[pc] = v;
		pc = pc + 16'h1;
	endtask : emit

	function automatic logic [15:0] btg();
		return pc + {{8{mem[pc - 16'h1][7]}}, mem[pc - 16'h1]};
	endfunction : btg

	task automatic note(input int c, input logic bv);
		q.push_back('{ma, mb, mf, mx, my, msp, 4'(c), bv, btg()});
	endtask : note

	task automatic do_sub(input int w, input logic [15:0] m);
		logic [16:0] r;
		logic [15:0] d;
		int k;
		k = (w == 2) ? 15 : 7;
		d = (w == 0) ? {8'h00, ma} : (w == 1) ? {8'h00, mb} : {ma, mb};
		r = {1'b0, d} - {1'b0, m};
		mf[CC_N] = r[k];
		mf[CC_Z] = (w == 2) ? (r[15:0] == 16'h0) : (r[7:0] == 8'h00);
		mf[CC_V] = (d[k] ^ m[k]) & (d[k] ^ r[k]);
		mf[CC_C] = r[k + 1];
		if (w == 0) ma = r[7:0];
		else if (w == 1) mb = r[7:0];
		else {ma, mb} = r[15:0];
	endtask : do_sub

	task automatic set_nz(input logic [7:0] v);
		mf[CC_N] = v[7];
		mf[CC_Z] = (v == 8'h00);
		mf[CC_V] = 1'b0;
		mf[CC_C] = 1'b0;
	endtask : set_nz

	task automatic lda(input logic [7:0] v);
		logic [7:0] o;
		o = ma - v;
		emit(8'h80);
		emit(o);
		do_sub(0, {8'h00, o});
		note(2, 1'b1);
	endtask : lda

	task automatic sub_op(input int w, input int md);
		logic [7:0] o1, o2, op;
		logic [15:0] ea, m;
		o1 = $random(seed);
		o2 = $random(seed);
		op = (w == 0) ? 8'h80 : (w == 1) ? 8'hc0 : 8'h83;
		op = op + ((md == 1) ? 8'h10 : (md == 2) ? 8'h30 : (md >= 3) ? 8'h20 : 8'h00);
		if (md == 4) emit(8'h18);
		emit(op);
		if (md == 0) begin
			emit(o1);
			if (w == 2) emit(o2);
			m = (w == 2) ? {o1, o2} : {8'h00, o1};
		end else begin
			// extended data kept below the program area
			if (md == 2) begin
				o1[7] = 1'b0;
				emit(o1);
				emit(o2);
				ea = {o1, o2};
			end else begin
				emit(o1);
				ea = (md == 1) ? {8'h00, o1} : ((md == 3) ? mx : my) + {8'h00, o1};
			end
			m = (w == 2) ? {mem[ea], mem[ea + 16'h1]} : {8'h00, mem[ea]};
		end
		do_sub(w, m);
		note(cyc_tab[md] + ((w == 2) ? 2 : 0), 1'b1);
	endtask : sub_op

	task automatic tst_mem(input int md);
		logic [7:0] o1, o2;
		logic [15:0] ea;
		o1 = $random(seed);
		o2 = $random(seed);
		if (md == 2) emit(8'h18);
		emit((md == 0) ? 8'h7d : 8'h6d);
		if (md == 0) begin
			o1[7] = 1'b0;
			emit(o1);
			emit(o2);
			ea = {o1, o2};
		end else begin
			emit(o1);
			ea = ((md == 1) ? mx : my) + {8'h00, o1};
		end
		set_nz(mem[ea]);
		note((md == 2) ? 7 : 6, 1'b1);
	endtask : tst_mem

	// flag load keeps the X mask from rising
	task automatic inh(input logic [7:0] op, input logic y);
		logic [15:0] t;
		if (y) emit(8'h18);
		emit(op);
		case (op)
			8'h4d: set_nz(ma);
			8'h5d: set_nz(mb);
			8'h06: mf = {ma[7], mf[6] & ma[6], ma[5:0]};
			8'h07: ma = mf;
			8'h30: if (y) my = msp + 16'h1; else mx = msp + 16'h1;
			8'h35: msp = (y ? my : mx) - 16'h1;
			8'h8f: begin
				t = y ? my : mx;
				if (y) my = {ma, mb}; else mx = {ma, mb};
				{ma, mb} = t;
			end
			default: ;
		endcase
		note((op == 8'h30 || op == 8'h35 || op == 8'h8f) ? 3 + int'(y) : 2, 1'b0);
	endtask : inh

	task automatic end_sim();
		$display("counts: compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	task automatic timed_out(input string what);
		err_total++;
		$display("CHECK FAILED %s expected done seen timeout", what);
		end_sim();
	endtask : timed_out

	always @(posedge clk_in) begin
		cst_exp_t e;
		clk_cnt++;
		if (srst_in === 1'b0 && inst_done_out === 1'b1) begin
			if (q.size() == 0) begin
				err_total++;
				$display("CHECK FAILED inst_done expected none seen 1");
			end else begin
				e = q.pop_front();
				`CHK("acc_a", e.a, acc_a_out)
				`CHK("acc_b", e.b, acc_b_out)
				`CHK("flags", e.f, flags_out)
				`CHK("index_x", e.x, index_x_out)
				`CHK("index_y", e.y, index_y_out)
				`CHK("stackptr", e.sp, stackptr_out)
				if (e.bv) `CHK("branch_target", e.bt, branch_target_out)
				if (e.cyc != 4'h0) `CHK("cycles", int'(e.cyc) * EDIV, clk_cnt - last_done)
			end
			last_done = clk_cnt;
		end
	end

	initial begin
		logic [7:0] sa, sf;
		logic [15:0] sp0, pcw, a0;
		int i;
		seed = 32'h8663;
		for (i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
		{ma, mb, mf, mx, my, msp, pc} = {8'h00, 8'h00, 8'hd0, 16'h0, 16'h0, 16'h01ff, 16'h8000};
		// opcode 00 without test mode is a plain two-cycle step
		inh(8'h00, 1'b0);
		q[0].cyc = 4'h0;
		lda(8'hff);
		inh(8'h06, 1'b0);
		lda(8'h00);
		inh(8'h06, 1'b0);
		lda(8'hff);
		inh(8'h06, 1'b0);
		inh(8'h07, 1'b0);
		lda(8'h30);
		inh(8'h8f, 1'b0);
		lda(8'h50);
		inh(8'h8f, 1'b1);
		for (int r = 0; r < 3; r++) begin
			for (int w = 0; w < 3; w++) for (int md = 0; md < 5; md++) sub_op(w, md);
			for (int md = 0; md < 3; md++) tst_mem(md);
			inh(8'h4d, 1'b0);
			inh(8'h5d, 1'b0);
		end
		inh(8'h35, 1'b0);
		inh(8'h35, 1'b1);
		inh(8'h30, 1'b0);
		inh(8'h30, 1'b1);
		inh(8'h8f, 1'b0);
		inh(8'h8f, 1'b1);
		lda(8'h2b);
		inh(8'h06, 1'b0);
		emit(8'h3e);
		{sp0, pcw, sa, sf} = {msp, pc, ma, mf};
		msp = msp - 16'h9;
		mf[CC_I] = 1'b1;
		{mem[16'hfff2], mem[16'hfff3], pc} = {8'h90, 8'h00, 16'h9000};
		inh(8'h4d, 1'b0);
		q[$].cyc = 4'h0;
		emit(8'h00);
		repeat (12) @(negedge clk_in);
		srst_in = 1'b0;
		for (i = 0; i < 20000 && waiting_out !== 1'b1; i++) @(negedge clk_in);
		if (i == 20000) timed_out("wait entry");
		`CHK("notes_left", 1, q.size())
		`CHK("pc_hold", pcw, pc_out)
		$display("test program finished");
		test_mode_in = 1'b1;
		repeat (10) @(negedge clk_in);
		irq_n_in = 1'b0;
		for (i = 0; i < 400 && q.size() != 0; i++) @(negedge clk_in);
		if (i == 400) timed_out("wake");
		irq_n_in = 1'b1;
		`CHK("stack_pcl", pcw[7:0], mem[sp0])
		`CHK("stack_a", sa, mem[sp0 - 16'h6])
		`CHK("stack_flags", sf, mem[sp0 - 16'h8])
		`CHK("waiting", 1'b0, waiting_out)
		$display("test wait finished");
		repeat (4 * EDIV) @(negedge clk_in);
		a0 = addr_out;
		for (i = 1; i <= 8; i++) begin
			repeat (EDIV) @(negedge clk_in);
			`CHK("test_addr", a0 + 16'(i), addr_out)
			`CHK("test_rw", 1'b1, rw_out)
			`CHK("test_data", 8'h00, data_out)
		end
		$display("test address walk finished");
		end_sim();
	end
endmodule : cpu_subtract_transfer_test_ops_tb
